// >>> verilog/load_switch_pkg.sv
// constants for the load switch sequencer
package load_switch_pkg;

	// register offsets (byte addresses, word aligned)
	localparam logic [7:0] ADDR_CTRL   = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_IRQ    = 8'h08;
	localparam logic [7:0] ADDR_MASK   = 8'h0C;

	// control register fields
	localparam int CTRL_AUTO   = 0;
	localparam int CTRL_WIDTH  = 1;
	localparam logic [0:0] CTRL_RESET = 1'h0;

	// interrupt event bit positions
	localparam int EV_ON     = 0;
	localparam int EV_OFF    = 1;
	localparam int EV_OTG    = 2;
	localparam int EV_VALID  = 3;
	localparam int EV_WIDTH  = 4;

	// status register fields
	localparam int ST_STATE_LO = 0;
	localparam int ST_STATE_HI = 2;
	localparam int ST_OTG      = 3;
	localparam int ST_VALID    = 4;
	localparam int ST_DISCH    = 5;

	// timing figures as printed
	localparam int CLK_MHZ      = 125;
	localparam int DEBOUNCE_MS  = 50;
	localparam int BBM_MS       = 50;
	localparam int LDELAY_US    = 100;
	localparam int SOFTSTART_US = 350;

	// derived cycle counts
	localparam int DEBOUNCE_CYC  = DEBOUNCE_MS * 1000 * CLK_MHZ;
	localparam int BBM_CYC       = BBM_MS * 1000 * CLK_MHZ;
	localparam int LDELAY_CYC    = LDELAY_US * CLK_MHZ;
	localparam int SOFTSTART_CYC = SOFTSTART_US * CLK_MHZ;

	localparam int CNT_W = 24;

	// sequencer states
	typedef enum logic [2:0]
	{
		ST_OFF   = 3'b000,
		ST_DLY   = 3'b001,
		ST_BBM   = 3'b010,
		ST_SOFT  = 3'b011,
		ST_ON    = 3'b100,
		ST_OFFDL = 3'b101
	} seq_state_e;

endpackage

// >>> verilog/load_switch_otg_sequencer.sv
// sequencer for a bidirectional load switch with input mux and otg flag
`timescale 1ns/1ps
`default_nettype none
module load_switch_otg_sequencer #(
	parameter int DEBOUNCE_CYC  = load_switch_pkg::DEBOUNCE_CYC,
	parameter int BBM_CYC       = load_switch_pkg::BBM_CYC,
	parameter int LDELAY_CYC    = load_switch_pkg::LDELAY_CYC,
	parameter int SOFTSTART_CYC = load_switch_pkg::SOFTSTART_CYC
)
(
	// clock, reset, enable
	input  wire logic        ref_clk,
	input  wire logic        arst_n,
	input  wire logic        clk_en,
	// register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	output logic             irq,
	// sense and control pins
	input  wire logic        input_sense,
	input  wire logic        output_sense,
	input  wire logic        fault,
	input  wire logic        enable_n,
	input  wire logic        wireless_receiver_dis,
	// flag pin, two-way
	input  wire logic        flag_n_in,
	output logic             flag_n_out,
	output logic             flag_n_oe,
	// power stage
	output logic             switch_on,
	output logic             soft_start,
	output logic             discharge,
	output logic             wireless_receiver_off,
	output logic             charge_ok_status_out,
	output logic             charge_ok_status_oe
);

	// ----------------------------------------
	// functions
	// ----------------------------------------
	// states in which the switch conducts
	function automatic logic is_on_state(input load_switch_pkg::seq_state_e s);
		return (s == load_switch_pkg::ST_SOFT) || (s == load_switch_pkg::ST_ON)
			|| (s == load_switch_pkg::ST_OFFDL);
	endfunction

	// register offset match
	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		return a == off;
	endfunction

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	localparam int NSYNC = 6;
	// bit positions of the pins in the synchroniser vector
	localparam int PIN_FLAG  = 0;
	localparam int PIN_RXDIS = 1;
	localparam int PIN_EN_N  = 2;
	localparam int PIN_FAULT = 3;
	localparam int PIN_OUT   = 4;
	localparam int PIN_IN    = 5;
	// idle levels after reset: flag pulled up, enable released high
	localparam logic [NSYNC-1:0] SYNC_IDLE = 6'h05;
	wire  [NSYNC-1:0] sync2_q;
	wire  [NSYNC-1:0] pins_raw = {input_sense, output_sense, fault, enable_n, wireless_receiver_dis, flag_n_in};

	// two flops per pin, reset to idle so no false request follows reset
	generate
		for (genvar gi = 0; gi < NSYNC; gi++)
		begin : g_sync
			logic s1_q;
			logic s2_q;
			always_ff @(posedge ref_clk or negedge arst_n)
			begin
				if (!arst_n)
				begin
					s1_q <= SYNC_IDLE[gi];
					s2_q <= SYNC_IDLE[gi];
				end
				else if (clk_en)
				begin
					s1_q <= pins_raw[gi];
					s2_q <= s1_q;
				end
			end
			assign sync2_q[gi] = s2_q;
		end
	endgenerate

	wire in_raw  = sync2_q[PIN_IN];
	wire out_ok  = sync2_q[PIN_OUT]; // no debounce on output sense
	wire flt     = sync2_q[PIN_FAULT];
	wire en_n_s  = sync2_q[PIN_EN_N];
	wire rx_dis  = sync2_q[PIN_RXDIS];
	wire flag_s  = sync2_q[PIN_FLAG];

	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic                 auto_q;
	logic [load_switch_pkg::EV_WIDTH-1:0] irq_st_q;
	logic [load_switch_pkg::EV_WIDTH-1:0] irq_mask_q;
	logic [31:0]          rdata_q;

	// write decodes; reads use the same offsets below
	// unmapped offsets are dropped silently
	wire wr_ctrl = reg_wr && hit(reg_addr, load_switch_pkg::ADDR_CTRL);
	wire wr_irq  = reg_wr && hit(reg_addr, load_switch_pkg::ADDR_IRQ);
	wire wr_mask = reg_wr && hit(reg_addr, load_switch_pkg::ADDR_MASK);

	// ----------------------------------------
	// input debounce
	// ----------------------------------------
	logic [load_switch_pkg::CNT_W-1:0] deb_cnt_q;
	logic                              in_valid_q;

	// input must hold high for the full debounce time
	// any low restarts the count, so contact bounce never qualifies
	// the output sense takes no such filter and acts at once
	// the counter stops at the top; it cannot wrap back to zero
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			deb_cnt_q  <= '0;
			in_valid_q <= 1'b0;
		end
		else if (clk_en)
		begin
			if (!in_raw)
			begin
				deb_cnt_q  <= '0;
				in_valid_q <= 1'b0;
			end
			else if (deb_cnt_q == DEBOUNCE_CYC[load_switch_pkg::CNT_W-1:0] - 1'b1)
				in_valid_q <= 1'b1;
			else
				deb_cnt_q <= deb_cnt_q + 1'b1;
		end
	end

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	load_switch_pkg::seq_state_e state_q;
	load_switch_pkg::seq_state_e state_d;
	logic [load_switch_pkg::CNT_W-1:0] tmr_q;
	logic                              otg_q;
	logic                              otg_d;
	logic                              rx_dis_d;

	// sequence to switch on: turn-on delay, optional break-before-make,
	// then soft-start, then on; switching off passes the turn-off delay, which a fault cuts short
	// break-before-make is skipped for otg, where the output side is the
	// source and discharging it would pull down the supply being shared
	// a fault drops every request at once, so the flag line is ignored
	// while it stands and no new sequence can begin
	// otg is refused whenever the input is already valid
	// leaving otg: a valid input takes the switch back through off
	// autonomous otg request: flag low, input absent, output valid, no fault
	wire otg_req_auto  = !flag_s && !in_raw && out_ok && !flt;
	// slave otg request
	wire otg_req_slave = !en_n_s && !in_raw && out_ok && !flt;
	// request to be on
	wire want_auto  = in_valid_q || otg_req_auto;
	wire want_slave = (!en_n_s && in_valid_q) || otg_req_slave;
	wire want_on    = !flt && (auto_q ? want_auto : want_slave);
	wire want_otg   = auto_q ? (otg_req_auto && !in_valid_q) : (otg_req_slave && !in_valid_q);
	// break-before-make only for powered input rise or receiver disable
	wire need_bbm   = auto_q && (in_valid_q || rx_dis);
	wire tmr_done   = (tmr_q == '0);

	// next state
	always_comb
	begin
		state_d  = state_q;
		otg_d    = otg_q;
		rx_dis_d = 1'b0;
		case (state_q)
			load_switch_pkg::ST_OFF:
				if (want_on)
				begin
					state_d = load_switch_pkg::ST_DLY;
					otg_d   = want_otg;
				end
			load_switch_pkg::ST_DLY:
				if (!want_on)
					state_d = load_switch_pkg::ST_OFF;
				else if (tmr_done)
					state_d = need_bbm && !otg_q ? load_switch_pkg::ST_BBM
						: load_switch_pkg::ST_SOFT;
			load_switch_pkg::ST_BBM:
				if (!want_on)
					state_d = load_switch_pkg::ST_OFF;
				else if (tmr_done)
					state_d = load_switch_pkg::ST_SOFT;
			load_switch_pkg::ST_SOFT:
				if (!want_on)
					state_d = load_switch_pkg::ST_OFFDL;
				else if (tmr_done)
					state_d = load_switch_pkg::ST_ON;
			load_switch_pkg::ST_ON:
				if (!want_on || (otg_q && in_valid_q))
					state_d = load_switch_pkg::ST_OFFDL;
			load_switch_pkg::ST_OFFDL:
				if (flt || tmr_done)
					state_d = load_switch_pkg::ST_OFF;
			default:
				state_d = load_switch_pkg::ST_OFF;
		endcase
	end

	wire enter = (state_d != state_q);
	logic [load_switch_pkg::CNT_W-1:0] tmr_load;

	// timer reload on entry to a timed state
	// a state left and entered again later starts from a full count
	// the load is one less than the cycle figure so the count ends on zero
	// untimed states load zero, which reads as already done
	always_comb
	begin
		case (state_d)
			load_switch_pkg::ST_DLY:   tmr_load = LDELAY_CYC[load_switch_pkg::CNT_W-1:0] - 1'b1;
			load_switch_pkg::ST_BBM:   tmr_load = BBM_CYC[load_switch_pkg::CNT_W-1:0] - 1'b1;
			load_switch_pkg::ST_SOFT:  tmr_load = SOFTSTART_CYC[load_switch_pkg::CNT_W-1:0] - 1'b1;
			load_switch_pkg::ST_OFFDL: tmr_load = LDELAY_CYC[load_switch_pkg::CNT_W-1:0] - 1'b1;
			default:                   tmr_load = '0;
		endcase
	end

	// state, timer and otg flag
	// the otg mark is cleared whenever the sequence falls back to off
	// the timer loads on every state change, otherwise runs down to zero
	// and holds there
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_q <= load_switch_pkg::ST_OFF;
			tmr_q   <= '0;
			otg_q   <= 1'b0;
		end
		else if (clk_en)
		begin
			state_q <= state_d;
			otg_q   <= (state_d == load_switch_pkg::ST_OFF) ? 1'b0 : otg_d;
			if (enter)
				tmr_q <= tmr_load;
			else if (!tmr_done)
				tmr_q <= tmr_q - 1'b1;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	wire on_d    = is_on_state(state_d);
	// flag drive releases as soon as the switch is asked to conduct
	// or the controller takes the line low
	wire flag_drive = auto_q && !in_raw && out_ok && flag_s && !on_d;
	wire otg_on  = on_d && otg_d && (state_d != load_switch_pkg::ST_OFF);

	// event detection
	// each event is a one-cycle pulse taken against the registered outputs
	// so a state that lasts many cycles reports once
	// the input valid event fires on the rising edge only
	logic in_valid_dq;
	wire [load_switch_pkg::EV_WIDTH-1:0] ev;
	assign ev[load_switch_pkg::EV_ON]    = on_d && !switch_on;
	assign ev[load_switch_pkg::EV_OFF]   = !on_d && switch_on;
	assign ev[load_switch_pkg::EV_OTG]   = otg_on && !charge_ok_status_oe;
	assign ev[load_switch_pkg::EV_VALID] = in_valid_q && !in_valid_dq;

	// pin drivers
	// every pin is a flop so no decode glitch reaches the power stage
	// the flag pin is only ever driven high; low comes from the controller
	// charge-ok is driven low or released, never driven high
	// the receiver is held off while the input is valid in autonomous mode
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			switch_on             <= 1'b0;
			soft_start            <= 1'b0;
			discharge             <= 1'b0;
			wireless_receiver_off <= 1'b0;
			flag_n_out            <= 1'b0;
			flag_n_oe             <= 1'b0;
			charge_ok_status_out  <= 1'b0;
			charge_ok_status_oe   <= 1'b0;
			in_valid_dq           <= 1'b0;
		end
		else if (clk_en)
		begin
			switch_on             <= on_d;
			soft_start            <= (state_d == load_switch_pkg::ST_SOFT);
			discharge             <= (state_d == load_switch_pkg::ST_BBM);
			wireless_receiver_off <= auto_q && in_valid_q;
			flag_n_out            <= 1'b1;
			flag_n_oe             <= flag_drive;
			charge_ok_status_out  <= 1'b0;
			charge_ok_status_oe   <= otg_on;
			in_valid_dq           <= in_valid_q;
		end
	end

	// ----------------------------------------
	// register file and interrupt
	// ----------------------------------------
	logic [31:0] status_word;

	// status word assembled field by field
	always_comb
	begin
		status_word = 32'h0;
		status_word[load_switch_pkg::ST_STATE_HI:load_switch_pkg::ST_STATE_LO] = state_q;
		status_word[load_switch_pkg::ST_OTG]   = otg_q;
		status_word[load_switch_pkg::ST_VALID] = in_valid_q;
		status_word[load_switch_pkg::ST_DISCH] = discharge;
	end

	// read mux
	wire [31:0] rd_mux =
		(reg_addr == load_switch_pkg::ADDR_CTRL)   ? {31'h0, auto_q} :
		(reg_addr == load_switch_pkg::ADDR_STATUS) ? status_word :
		(reg_addr == load_switch_pkg::ADDR_IRQ)    ? {28'h0, irq_st_q} :
		(reg_addr == load_switch_pkg::ADDR_MASK)   ? {28'h0, irq_mask_q} : 32'h0;

	// registers; set wins over write-one-to-clear
	// a write of one clears a bit, but an event in the same cycle keeps it
	// the interrupt line follows one cycle after the status and mask
	// the bus never stalls: read data stand in the cycle after the strobe
	// and read as zero at all other times
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			auto_q     <= load_switch_pkg::CTRL_RESET;
			irq_st_q   <= '0;
			irq_mask_q <= '0;
			rdata_q    <= 32'h0;
			irq        <= 1'b0;
		end
		else if (clk_en)
		begin
			if (wr_ctrl)
				auto_q <= reg_wdata[load_switch_pkg::CTRL_AUTO];
			if (wr_mask)
				irq_mask_q <= reg_wdata[load_switch_pkg::EV_WIDTH-1:0];
			irq_st_q <= (irq_st_q & ~(wr_irq ? reg_wdata[load_switch_pkg::EV_WIDTH-1:0] : '0)) | ev;
			rdata_q  <= reg_rd ? rd_mux : 32'h0;
			irq      <= |(irq_st_q & irq_mask_q);
		end
	end

	assign reg_rdata = rdata_q;

endmodule
`default_nettype wire

// >>> testbench/load_switch_otg_sequencer_properties.sv
// port assertions for the load switch sequencer
`timescale 1ns/1ps
`default_nettype none
module load_switch_otg_sequencer_properties (
	// clock and reset
	input wire logic        ref_clk,
	input wire logic        arst_n,
	// watched ports
	input wire logic        enable_n,
	input wire logic        flag_n_in,
	input wire logic        reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic        flag_n_out,
	input wire logic        flag_n_oe,
	input wire logic        switch_on,
	input wire logic        soft_start,
	input wire logic        discharge,
	input wire logic        wireless_receiver_off,
	input wire logic        charge_ok_status_out,
	input wire logic        charge_ok_status_oe
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	// output relations
	a_disch_switch_off: assert property (discharge |-> !switch_on) else $error("discharge with switch on");
	a_disch_rx_off: assert property (discharge |-> wireless_receiver_off) else $error("discharge, rx on");
	a_soft_in_on: assert property (soft_start |-> switch_on) else $error("soft start, switch off");
	a_soft_holds: assert property ($rose(soft_start) |=> soft_start[*3]) else $error("soft start short");
	a_charge_ok_status_on: assert property (charge_ok_status_oe |-> switch_on) else $error("charge ok while off");
	a_charge_ok_status_low: assert property (charge_ok_status_oe |-> !charge_ok_status_out) else $error("charge ok high");
	a_flag_high: assert property (flag_n_oe |-> flag_n_out) else $error("flag driven low");
	a_turn_on_delay: assert property (($fell(enable_n) || $fell(flag_n_in)) && !switch_on |=> !switch_on[*5])
		else $error("turn on too early");
	a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0) else $error("read data outside slot");
endmodule
bind load_switch_otg_sequencer load_switch_otg_sequencer_properties i_props (.ref_clk(ref_clk), .arst_n(arst_n),
	.enable_n(enable_n), .flag_n_in(flag_n_in), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .flag_n_out(flag_n_out),
	.flag_n_oe(flag_n_oe), .switch_on(switch_on), .soft_start(soft_start), .discharge(discharge),
	.wireless_receiver_off(wireless_receiver_off), .charge_ok_status_out(charge_ok_status_out),
	.charge_ok_status_oe(charge_ok_status_oe));
`default_nettype wire

// >>> testbench/flag_line_model.sv
// controller side of the open-drain flag line
`timescale 1ns/1ps
`default_nettype none
module flag_line_model (
	// controller request
	input  wire logic pull_low,
	// device side of the pin
	input  wire logic flag_n_out,
	input  wire logic flag_n_oe,
	output logic      flag_n_in
);
	// controller low wins, else device level or pull-up
	assign flag_n_in = pull_low ? 1'b0 : (flag_n_oe ? flag_n_out : 1'b1);
endmodule
`default_nettype wire

// >>> testbench/load_switch_otg_sequencer_tb.sv
// testbench for the load switch sequencer
`timescale 1ns/1ps
`default_nettype none
module load_switch_otg_sequencer_tb;
	localparam int DEB = 20;
	localparam int BBM = 20;
	localparam int LDL = 5;
	logic        ref_clk, arst_n, reg_wr, reg_rd, irq, pull_low;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata;
	logic        input_sense, output_sense, fault, enable_n, rx_dis, flag_n_in, flag_n_out, flag_n_oe;
	logic        switch_on, soft_start, discharge, rx_off, chg_out, chg_oe, clk_en;
	int          n_mismatch, checks, cyc, dis_n, n;

	load_switch_otg_sequencer #(.DEBOUNCE_CYC(DEB), .BBM_CYC(BBM), .LDELAY_CYC(LDL), .SOFTSTART_CYC(5))
	i_load_switch_otg_sequencer (.ref_clk(ref_clk), .arst_n(arst_n), .clk_en(clk_en), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
		.input_sense(input_sense), .output_sense(output_sense), .fault(fault), .enable_n(enable_n),
		.wireless_receiver_dis(rx_dis), .flag_n_in(flag_n_in), .flag_n_out(flag_n_out), .flag_n_oe(flag_n_oe),
		.switch_on(switch_on), .soft_start(soft_start), .discharge(discharge), .wireless_receiver_off(rx_off),
		.charge_ok_status_out(chg_out), .charge_ok_status_oe(chg_oe));
	flag_line_model i_flag_line_model (.pull_low(pull_low), .flag_n_out(flag_n_out), .flag_n_oe(flag_n_oe),
		.flag_n_in(flag_n_in));

	// clock
	initial
	begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end

	// discharge cycle count and hang guard
	always @(posedge ref_clk)
	begin
		dis_n <= !arst_n ? 0 : dis_n + int'(discharge === 1'b1);
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			n_mismatch++;
			wrap_up();
		end
	end

	task automatic chk(input bit ok, input string m);
		checks++;
		if (!ok)
		begin
			n_mismatch++;
			$display("ERROR %0t %s", $time, m);
		end
	endtask

	task automatic wrap_up;
		if (n_mismatch == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata === e, "read data");
	endtask

	task automatic wait_sw(input logic v, input int lim);
		n = 0;
		while (switch_on !== v && n < lim)
		begin
			@(posedge ref_clk);
			#1 n++;
		end
	endtask

	task automatic rst;
		@(posedge ref_clk);
		arst_n <= 1'b0;
		input_sense <= 1'b0;
		enable_n <= 1'b1;
		pull_low <= 1'b0;
		repeat (6) @(posedge ref_clk);
		arst_n <= 1'b1;
	endtask

	// slave turn-on, interrupt, turn-off
	task automatic t_slave;
		rst();
		rd(load_switch_pkg::ADDR_CTRL, 32'h0);
		rd(8'h10, 32'h0);
		wr(load_switch_pkg::ADDR_MASK, 32'h1);
		input_sense <= 1'b1;
		enable_n <= 1'b0;
		wait_sw(1'b1, 80);
		chk(n >= DEB + LDL && soft_start === 1'b1, "slave on timing");
		chk(dis_n == 0, "discharge in slave mode");
		repeat (2) @(posedge ref_clk);
		#1 chk(irq === 1'b1, "irq not raised");
		rd(load_switch_pkg::ADDR_IRQ, 32'h9);
		wr(load_switch_pkg::ADDR_IRQ, 32'h9);
		repeat (2) @(posedge ref_clk);
		#1 chk(irq === 1'b0, "irq not cleared");
		clk_en <= 1'b0;
		enable_n <= 1'b1;
		repeat (12) @(posedge ref_clk);
		#1 chk(switch_on === 1'b1 && irq === 1'b0, "state moved while frozen");
		clk_en <= 1'b1;
		wait_sw(1'b0, 40);
		chk(n >= LDL && switch_on === 1'b0, "slave off");
	endtask

	// autonomous input rise then removal
	task automatic t_auto_in;
		rst();
		wr(load_switch_pkg::ADDR_CTRL, 32'h1);
		input_sense <= 1'b1;
		enable_n <= 1'b0;
		wait_sw(1'b1, 150);
		chk(n >= DEB + BBM && dis_n >= BBM - 1 && dis_n <= BBM + 1, "auto bbm");
		chk(rx_off === 1'b1, "receiver left enabled");
		input_sense <= 1'b0;
		wait_sw(1'b0, 40);
		chk(switch_on === 1'b0 && dis_n <= BBM + 1, "bbm on removal");
	endtask

	// autonomous otg through the flag line
	task automatic t_auto_otg;
		rst();
		wr(load_switch_pkg::ADDR_CTRL, 32'h1);
		output_sense <= 1'b1;
		repeat (10) @(posedge ref_clk);
		#1 chk(flag_n_oe === 1'b1 && flag_n_out === 1'b1 && chg_oe === 1'b0, "flag idle");
		@(posedge ref_clk);
		fault <= 1'b1;
		repeat (4) @(posedge ref_clk);
		pull_low <= 1'b1;
		wait_sw(1'b1, 30);
		chk(switch_on === 1'b0, "flag taken in fault");
		pull_low <= 1'b0;
		fault <= 1'b0;
		repeat (4) @(posedge ref_clk);
		pull_low <= 1'b1;
		wait_sw(1'b1, 40);
		chk(n >= LDL && soft_start === 1'b1, "otg on");
		repeat (3) @(posedge ref_clk);
		#1 chk(chg_oe === 1'b1 && chg_out === 1'b0, "charge ok in otg");
	endtask

	// slave otg: enable low with output valid and no input
	task automatic t_slave_otg;
		rst();
		output_sense <= 1'b1;
		enable_n <= 1'b0;
		wait_sw(1'b1, 40);
		chk(n >= LDL && switch_on === 1'b1, "slave otg on");
		repeat (2) @(posedge ref_clk);
		#1 chk(chg_oe === 1'b1 && chg_out === 1'b0 && flag_n_oe === 1'b0, "slave otg charge ok");
	endtask

	// main sequence
	initial
	begin
		{arst_n, reg_wr, reg_rd, input_sense, output_sense, fault, enable_n, rx_dis, pull_low} = '0;
		reg_addr = 8'h00;
		clk_en = 1'b1;
		reg_wdata = 32'h0;
		{n_mismatch, checks, cyc, dis_n} = '0;
		t_slave();
		t_auto_in();
		t_auto_otg();
		t_slave_otg();
		wrap_up();
	end
endmodule
`default_nettype wire
